/* adc_control_word_one.sv */
// converter control word one with bus slave and sequencer
//
// Summary of operation
// - bit 15 on runs the converter; off stops the sequencer and clears the sample flag.
// - idle-stop bit set halts conversion while the device idles.
// - build mode 1: DMA address is the plain buffer, conversion order.
// - build mode 0: DMA address from channel and buffer size.
// - resolution bit 1 gives 12-bit one channel, 0 gives 10-bit four.
// - 10-bit format field selects integer, signed, fraction, signed fraction.
// - 12-bit format field selects integer, signed, fraction, signed fraction.
// - sample and done flags set by hardware; software only clears done.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module adc_control_word_one (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        device_idle,
    input  wire logic        sample_trigger,
    input  wire logic [11:0] raw_sample,
    output logic      [1:0]  channel_sel,
    output logic             result_valid,
    output logic      [15:0] dma_address,
    output logic             irq
);
    import adc_ctl_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [15:0]  ctl_reg;
    logic [15:0]  result_reg;
    logic [15:0]  dma_base_reg;
    logic [3:0]   dma_size_reg;
    logic [1:0]   status_reg;
    logic [1:0]   mask_reg;
    logic         wr_pend_reg;
    logic [7:0]   wr_addr_reg;
    conv_state_t  state_reg;
    logic [3:0]   cnt_reg;
    logic [1:0]   chan_reg;
    logic [15:0]  fmt_word;
    logic         running;
    logic         sample_start;
    logic         conv_end;
    logic         sw_clear_done;
    logic [15:0]  wdata16;
    logic [15:0]  rd_next;

    assign wdata16 = hwdata[15:0];
    assign running = ctl_reg[BIT_ON]
                     && !(ctl_reg[BIT_IDLE_STOP] && device_idle);
    assign sample_start = (state_reg == ST_OFF) && running
                          && (ctl_reg[BIT_AUTO_SAMPLE] || sample_trigger);
    assign conv_end = (state_reg == ST_CONVERT) && (cnt_reg == 4'h0);
    assign sw_clear_done = wr_pend_reg && (wr_addr_reg == OFS_CONTROL_ONE)
                           && !wdata16[BIT_DONE];

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        rd_next = 16'h0000;
        case (haddr)
            OFS_CONTROL_ONE: rd_next = ctl_reg;
            OFS_RESULT:      rd_next = result_reg;
            OFS_DMA_ADDR:    rd_next = dma_base_reg;
            OFS_IRQ_STATUS:  rd_next = {14'h0000, status_reg};
            OFS_IRQ_MASK:    rd_next = {14'h0000, mask_reg};
            OFS_DMA_CONFIG:  rd_next = {12'h000, dma_size_reg};
            default:         rd_next = 16'h0000;
        endcase
    end

    // read data loaded at the address phase edge, stands in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= {16'h0000, rd_next};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control word one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_reg <= CTL_RESET;
        end else begin
            if (wr_pend_reg && wr_addr_reg == OFS_CONTROL_ONE) begin
                ctl_reg[15:2] <= wdata16[15:2] & CTL_WRITE_MASK[15:2];
            end
            if (!running) begin
                ctl_reg[BIT_SAMPLE] <= 1'b0;
            end else if (sample_start) begin
                ctl_reg[BIT_SAMPLE] <= 1'b1;
            end else if (state_reg == ST_SAMPLE && cnt_reg == 4'h0) begin
                ctl_reg[BIT_SAMPLE] <= 1'b0;
            end
            if (conv_end) begin
                ctl_reg[BIT_DONE] <= 1'b1;
            end else if (sample_start || sw_clear_done) begin
                ctl_reg[BIT_DONE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_base_reg <= DMA_BASE_RESET;
            dma_size_reg <= DMA_SIZE_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == OFS_DMA_ADDR) begin
                dma_base_reg <= wdata16;
            end
            if (wr_addr_reg == OFS_DMA_CONFIG) begin
                dma_size_reg <= wdata16[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample and convert sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 4'h0;
        end else if (!running) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 4'h0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (sample_start) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= {1'b0, SAMPLE_CYCLES - 3'h1};
                    end
                end
                ST_SAMPLE: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_CONVERT;
                        cnt_reg   <= CONVERT_CYCLES - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ST_CONVERT: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_OFF;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    adc_result_formatter u_fmt (
        .raw_data   (raw_sample),
        .res_twelve (ctl_reg[BIT_RES_SEL]),
        .form_sel   (ctl_reg[BIT_FORM_LO+1:BIT_FORM_LO]),
        .word_out   (fmt_word)
    );

    // result, channel rotation and DMA address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_reg   <= 16'h0000;
            result_valid <= 1'b0;
            chan_reg     <= 2'h0;
            dma_address  <= 16'h0000;
        end else begin
            result_valid <= conv_end;
            if (conv_end) begin
                result_reg <= fmt_word;
                if (ctl_reg[BIT_BUILD_MODE]) begin
                    dma_address <= dma_base_reg;
                end else begin
                    dma_address <= dma_base_reg
                        + ({13'h0000, chan_reg, 1'b0} << dma_size_reg);
                end
                chan_reg <= ctl_reg[BIT_RES_SEL] ? 2'h0
                                                 : chan_reg + 2'h1;
            end
        end
    end
    assign channel_sel = chan_reg;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= STATUS_RESET;
            mask_reg   <= STATUS_RESET;
            irq        <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_DONE && conv_end)
                    || (i == IRQ_SAMPLE && sample_start)) begin
                    status_reg[i] <= 1'b1;
                end else if (wr_pend_reg && wr_addr_reg == OFS_IRQ_STATUS
                             && wdata16[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
            if (wr_pend_reg && wr_addr_reg == OFS_IRQ_MASK) begin
                mask_reg <= wdata16[1:0];
            end
            irq <= |(status_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_DONE_AT_END: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end |=> ctl_reg[BIT_DONE])
        else $error("done not set after conversion");
    AST_OFF_STOPS: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctl_reg[BIT_ON] |=> state_reg == ST_OFF)
        else $error("sequencer runs while off");
    AST_IDLE_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl_reg[BIT_IDLE_STOP] && device_idle |=> state_reg == ST_OFF)
        else $error("sequencer runs in idle");
    AST_BUILD_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end && ctl_reg[BIT_BUILD_MODE]
        |=> dma_address == $past(dma_base_reg))
        else $error("order mode address wrong");
    AST_SCATTER: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end && !ctl_reg[BIT_BUILD_MODE] && chan_reg != 2'h0
        && dma_size_reg != 4'hF |=> dma_address != $past(dma_base_reg))
        else $error("scatter address not offset");
    AST_ONE_CHANNEL: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end && ctl_reg[BIT_RES_SEL] |=> chan_reg == 2'h0)
        else $error("twelve bit mode left channel zero");
    AST_RESULT: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end |=> result_reg == $past(fmt_word) && result_valid)
        else $error("result word not stored");
    AST_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl_reg[14] == 1'b0 && ctl_reg[11] == 1'b0)
        else $error("reserved bits set");
    AST_SAMPLE_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_start && ctl_reg[BIT_ON] |=> ctl_reg[BIT_SAMPLE]
        ##4 !ctl_reg[BIT_SAMPLE])
        else $error("sample flag timing wrong");
endmodule : adc_control_word_one

/* adc_ctl_pkg.sv */
// constants for the converter control word block
package adc_ctl_pkg;
    localparam logic [7:0]  OFS_CONTROL_ONE  = 8'h00;
    localparam logic [7:0]  OFS_RESULT       = 8'h04;
    localparam logic [7:0]  OFS_DMA_ADDR     = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK     = 8'h10;
    localparam logic [7:0]  OFS_DMA_CONFIG   = 8'h14;
    localparam int          BIT_ON           = 15;
    localparam int          BIT_IDLE_STOP    = 13;
    localparam int          BIT_BUILD_MODE   = 12;
    localparam int          BIT_RES_SEL      = 10;
    localparam int          BIT_FORM_LO      = 8;
    localparam int          BIT_AUTO_SAMPLE  = 2;
    localparam int          BIT_SAMPLE       = 1;
    localparam int          BIT_DONE         = 0;
    localparam logic [15:0] CTL_WRITE_MASK   = 16'hB7FE;
    localparam logic [15:0] CTL_RESET        = 16'h0000;
    localparam logic [1:0]  FORM_INT         = 2'h0;
    localparam logic [1:0]  FORM_SINT        = 2'h1;
    localparam logic [1:0]  FORM_FRAC        = 2'h2;
    localparam logic [1:0]  FORM_SFRAC       = 2'h3;
    localparam logic [15:0] DMA_BASE_RESET   = 16'h0000;
    localparam logic [3:0]  DMA_SIZE_RESET   = 4'h0;
    localparam int          IRQ_DONE         = 0;
    localparam int          IRQ_SAMPLE       = 1;
    localparam logic [1:0]  STATUS_RESET     = 2'h0;
    localparam logic [2:0]  SAMPLE_CYCLES    = 3'h4;
    localparam logic [3:0]  CONVERT_CYCLES   = 4'hC;
    typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage : adc_ctl_pkg

/* adc_result_formatter.sv */
// result word formatter for both resolutions
`timescale 1ns/1ns
module adc_result_formatter (
    input  wire logic [11:0] raw_data,
    input  wire logic        res_twelve,
    input  wire logic [1:0]  form_sel,
    output logic      [15:0] word_out
);
    import adc_ctl_pkg::*;
    always_comb begin
        word_out = 16'h0000;
        if (res_twelve) begin
            case (form_sel)
                FORM_INT:   word_out = {4'h0, raw_data};
                FORM_SINT:  word_out = {{5{~raw_data[11]}},
                                        raw_data[10:0]};
                FORM_FRAC:  word_out = {raw_data, 4'h0};
                FORM_SFRAC: word_out = {~raw_data[11], raw_data[10:0],
                                        4'h0};
                default:    word_out = 16'h0000;
            endcase
        end else begin
            case (form_sel)
                FORM_INT:   word_out = {6'h00, raw_data[9:0]};
                FORM_SINT:  word_out = {{7{~raw_data[9]}},
                                        raw_data[8:0]};
                FORM_FRAC:  word_out = {raw_data[9:0], 6'h00};
                FORM_SFRAC: word_out = {~raw_data[9], raw_data[8:0],
                                        6'h00};
                default:    word_out = 16'h0000;
            endcase
        end
    end
endmodule : adc_result_formatter

/* adc_control_word_one_tb.sv */
// self-checking bench for converter control word one
`timescale 1ns/1ns
module adc_control_word_one_tb;
    import adc_ctl_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, channel_sel;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic        device_idle, sample_trigger, result_valid, irq, got;
    logic [11:0] raw_sample, raw;
    logic [15:0] dma_address, base, ctl;
    logic [3:0]  seen;
    integer      failures, check_count, seed, r, f, c;

    adc_control_word_one dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .device_idle(device_idle), .sample_trigger(sample_trigger),
        .raw_sample(raw_sample), .channel_sel(channel_sel),
        .result_valid(result_valid), .dma_address(dma_address), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] fmt(input logic t, input logic [1:0] s,
                                        input logic [11:0] d);
        if (t) begin
            case (s)
                2'h0: return {4'h0, d};
                2'h1: return {{5{~d[11]}}, d[10:0]};
                2'h2: return {d, 4'h0};
                default: return {~d[11], d[10:0], 4'h0};
            endcase
        end
        case (s)
            2'h0: return {6'h00, d[9:0]};
            2'h1: return {{7{~d[9]}}, d[8:0]};
            2'h2: return {d[9:0], 6'h00};
            default: return {~d[9], d[8:0], 6'h00};
        endcase
    endfunction : fmt

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] s);
        check_count = check_count + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wait_ready;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask : bus

    task automatic wait_valid(input integer lim);
        integer n;
        got = 1'b0;
        for (n = 0; n < lim && !got; n++) begin
            @(posedge hclk);
            if (result_valid === 1'b1) got = 1'b1;
        end
    endtask : wait_valid

    task automatic trig(input logic [15:0] k, input logic [11:0] d);
        bus(1'b1, OFS_CONTROL_ONE, {16'h0000, k});
        raw_sample <= d;
        sample_trigger <= 1'b1;
        @(posedge hclk);
        sample_trigger <= 1'b0;
    endtask : trig

    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        failures = failures + 1;
        close_out;
    end

    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {device_idle, sample_trigger, raw_sample} = '0;
        hsize = 3'h2;
        failures = 0;
        check_count = 0;
        seed = 39;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (r = 0; r < 7; r++) begin
            bus(1'b0, (r == 6) ? 8'h40 : 8'(r * 4), 32'h0);
            check("reset value", 32'h0, rd);
        end
        check("hresp", 32'h0, {31'h0, hresp});
        bus(1'b1, OFS_CONTROL_ONE, 32'h7FFD);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("control readback", 32'h37FC, rd);
        base = 16'($random(seed)) & 16'hFFFE;
        bus(1'b1, OFS_DMA_ADDR, {16'h0000, base});
        bus(1'b1, OFS_DMA_CONFIG, 32'h2);
        for (r = 0; r < 2; r++) begin
            for (f = 0; f < 4; f++) begin
                raw = (f == 0) ? 12'hFFF : 12'($random(seed));
                ctl = 16'h9000 | 16'(r << 10) | 16'(f << 8);
                trig(ctl, raw);
                wait_valid(60);
                check("valid", 32'h1, {31'h0, got});
                check("dma plain", {16'h0, base}, {16'h0, dma_address});
                if (r == 1) check("chan", 32'h0, {30'h0, channel_sel});
                bus(1'b0, OFS_RESULT, 32'h0);
                check("result", {16'h0, fmt(r[0], f[1:0], raw)}, rd);
                bus(1'b0, OFS_CONTROL_ONE, 32'h0);
                check("done", {16'h0, ctl | 16'h0001}, rd);
            end
        end
        seen = 4'h0;
        for (r = 0; r < 4; r++) begin
            trig(16'h8000, 12'($random(seed)));
            wait_valid(60);
            for (c = 0; c < 4; c++)
                if (dma_address === base + 16'((c * 2) << 2)) seen[c] = 1'b1;
        end
        check("scatter channels", 32'hF, {28'h0, seen});
        trig(16'h8001, 12'h5A5);
        @(posedge hclk);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("sample phase", 32'h2, {30'h0, rd[1:0]});
        wait_valid(60);
        bus(1'b1, OFS_IRQ_STATUS, 32'h3);
        bus(1'b1, OFS_IRQ_MASK, 32'h3);
        check("irq idle", 32'h0, {31'h0, irq});
        trig(16'h8000, 12'h123);
        wait_valid(60);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        check("status", 32'h3, rd);
        check("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_IRQ_STATUS, 32'h1);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        check("w1c", 32'h2, rd);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, OFS_CONTROL_ONE, 32'h8001);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("done kept", 32'h1, {31'h0, rd[0]});
        bus(1'b1, OFS_CONTROL_ONE, 32'h8000);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("done cleared", 32'h0, {31'h0, rd[0]});
        trig(16'h0000, 12'h321);
        wait_valid(40);
        check("off", 32'h0, {31'h0, got});
        device_idle <= 1'b1;
        trig(16'hA000, 12'h321);
        wait_valid(40);
        check("idle stop", 32'h0, {31'h0, got});
        bus(1'b1, OFS_CONTROL_ONE, 32'h0);
        trig(16'h8000, 12'h321);
        wait_valid(60);
        check("idle run", 32'h1, {31'h0, got});
        device_idle <= 1'b0;
        bus(1'b1, OFS_CONTROL_ONE, 32'h8005);
        for (r = 0; r < 2; r++) begin
            wait_valid(60);
            check("auto restart", 32'h1, {31'h0, got});
        end
        bus(1'b1, OFS_CONTROL_ONE, 32'h0001);
        close_out;
    end
endmodule : adc_control_word_one_tb
